/* hdl/ssw_pkg.sv */
/*
  Package for the side-set and program-counter wrap block: field layouts,
  widths, reset values and structs shared by the two design files.
  Assumes a single 25 MHz system clock and an asynchronous active-high reset.
*/
package ssw_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned PC_W      = 5;   // 32 instruction slots
  localparam int unsigned GPIO_N    = 32;  // GPIO count seen by the block
  localparam int unsigned GPIO_W    = 5;   // Width of a GPIO number
  localparam int unsigned FIELD_W   = 5;   // Delay/side-set field width
  localparam int unsigned CNT_W     = 3;   // Side-set count 0..5
  localparam int unsigned INSTR_W   = 16;

  // ==========================================================================
  // Instruction field positions
  localparam int unsigned FIELD_LSB = 8;
  localparam int unsigned FIELD_MSB = 12;

  // ==========================================================================
  // Constants and reset values
  localparam logic [PC_W-1:0]    PC_LAST       = 5'h1f;
  localparam logic [PC_W-1:0]    PC_RST        = 5'h00;
  localparam logic [PC_W-1:0]    PC_ONE        = 5'h01;
  localparam logic [CNT_W-1:0]   CNT_MAX       = 3'h5;
  localparam logic [FIELD_W-1:0] DELAY_ZERO    = 5'h00;
  localparam logic [FIELD_W-1:0] DELAY_ONE     = 5'h01;
  localparam logic [GPIO_N-1:0]  GPIO_RST      = 32'h00000000;

  // ==========================================================================
  // Configuration carried from the control registers
  typedef struct packed {
    logic [CNT_W-1:0]  side_bit_count;
    logic              side_enable_opt;
    logic [GPIO_W-1:0] side_first_gpio;
    logic              side_targets_direction;
    logic [PC_W-1:0]   loop_end_address;
    logic [PC_W-1:0]   loop_start_address;
  } ssw_cfg_t;

  // Per-instruction request from the execution core
  typedef struct packed {
    logic               valid;       // Instruction presented this cycle
    logic [INSTR_W-1:0] word;        // Full instruction word
    logic               stall;       // Core cannot finish it this cycle
    logic               jump_taken;  // Jump with condition true
    logic [PC_W-1:0]    jump_target;
  } ssw_exec_t;

  // Pin write request from OUT or SET
  typedef struct packed {
    logic [GPIO_N-1:0] mask;
    logic [GPIO_N-1:0] value;
  } ssw_pinwr_t;

endpackage

/* hdl/ssw_side_decode.sv */
/*
  Side-set decoder: splits the delay/side-set field into side-set data, an
  enable and a delay count, then maps the data onto a 32-bit GPIO mask.
  Assumes the count never exceeds five; larger values are clamped.
*/
`timescale 1ns/1ps
module ssw_side_decode (
  input  wire logic [ssw_pkg::FIELD_W-1:0] field_i,
  input  wire logic [ssw_pkg::CNT_W-1:0]   count_i,
  input  wire logic                        enable_opt_i,
  input  wire logic [ssw_pkg::GPIO_W-1:0]  first_gpio_i,
  output logic                             apply_o,
  output logic [ssw_pkg::GPIO_N-1:0]       mask_o,
  output logic [ssw_pkg::GPIO_N-1:0]       value_o,
  output logic [ssw_pkg::FIELD_W-1:0]      delay_o
);

  // ==========================================================================
  // Field split
  logic [ssw_pkg::CNT_W-1:0]   cnt;
  logic [ssw_pkg::CNT_W-1:0]   dly_bits;
  logic [ssw_pkg::CNT_W-1:0]   data_bits;
  logic [ssw_pkg::FIELD_W-1:0] side_raw;
  logic [ssw_pkg::FIELD_W-1:0] data_mask;
  logic                        en_bit;
  logic [ssw_pkg::GPIO_N-1:0]  data_wide;
  logic [ssw_pkg::GPIO_N-1:0]  mask_wide;

  // Clamp keeps a bad count from shifting garbage into the delay
  assign cnt       = (count_i > ssw_pkg::CNT_MAX) ? ssw_pkg::CNT_MAX : count_i;
  assign dly_bits  = ssw_pkg::CNT_MAX - cnt;
  // Side-set bits are the MSBs; shift them down to bit 0
  assign side_raw  = field_i >> dly_bits;
  // Delay is what is left at the LSB end
  assign delay_o   = field_i & ~({ssw_pkg::FIELD_W{1'b1}} << dly_bits);
  // Top side-set bit is always the field MSB, whatever the count
  assign en_bit    = (cnt != 3'h0) & field_i[ssw_pkg::FIELD_W-1];
  assign data_bits = (enable_opt_i && cnt != 3'h0) ? cnt - 3'h1 : cnt;
  assign data_mask = ~({ssw_pkg::FIELD_W{1'b1}} << data_bits);
  assign apply_o   = (cnt != 3'h0) && (!enable_opt_i || en_bit);

  // Rotate onto GPIOs so bits past the top wrap round to GPIO 0
  assign data_wide = {27'h0000000, side_raw & data_mask};
  assign mask_wide = {27'h0000000, data_mask};
  assign value_o   = (data_wide << first_gpio_i) | (data_wide >> (6'h20 - {1'b0, first_gpio_i}));
  assign mask_o    = apply_o ?
                     ((mask_wide << first_gpio_i) | (mask_wide >> (6'h20 - {1'b0, first_gpio_i})))
                     : ssw_pkg::GPIO_RST;

endmodule // ssw_side_decode

/* hdl/ssw_core.sv */
/*
  Per-state-machine side-set and program-counter logic.

  What this file holds:
  - The side-set path. Each instruction word carries a five-bit
    delay/side-set field; the decoder splits it into side-set data, an
    optional enable bit and a delay count, and maps the data onto a
    32-bit GPIO mask starting at the configured first GPIO.
  - The pin merge. OUT/SET level and direction writes are applied
    first and side-set is laid over them, so side-set wins on any pin
    that both touch in one cycle.
  - The sequencer. Three states: RUN takes an instruction, STALL holds
    a stalled one until the core lets it finish, DELAY idles for the
    encoded number of cycles after it retires.
  - The program counter. On retire it takes, in order of priority, a
    taken jump target, the wrap bottom when it sits on the wrap top,
    or its own value plus one, rolling from 31 to 0.

  Timing seen from the core:
  - An instruction is taken at the rising edge where it is valid in
    RUN. Its side-set shows on the pin outputs right after that edge, even
    when it stalls; later stall cycles do not repeat the side-set.
  - pc_o moves at the edge where the instruction retires, so the wrap
    costs no cycle of its own.
  - A delay of d gives d cycles with fetch_ready_o low after the
    retiring edge; a stalled instruction counts its delay only after
    the stall ends.
  - jump_taken and jump_target are looked at only in the retiring cycle.

  What it assumes of its surroundings:
  - One 25 MHz clock and an asynchronous active-high reset.
  - The core presents one instruction per cycle and re-presents a
    stalled one until stall drops; anything presented while
    fetch_ready_o is low is ignored.
  - Configuration inputs are held steady while the machine runs; the
    wrap addresses are absolute slot numbers, so software adds any
    program offset itself.
  - OUT/SET writes land in every cycle their mask is set, delay cycles
    included.
  - Side-set mapping wraps modulo 32, so a base near the top spills
    onto GPIO 0 and up; counts above five are clamped to five.
*/
`timescale 1ns/1ps

module ssw_core (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire ssw_pkg::ssw_cfg_t           cfg_i,
  input  wire ssw_pkg::ssw_exec_t          exec_i,
  input  wire ssw_pkg::ssw_pinwr_t         out_wr_i,
  input  wire ssw_pkg::ssw_pinwr_t         dir_wr_i,
  output logic [ssw_pkg::PC_W-1:0]         pc_o,
  output logic                             busy_o,
  output logic                             fetch_ready_o,
  output logic [ssw_pkg::GPIO_N-1:0]       pin_level_o,
  output logic [ssw_pkg::GPIO_N-1:0]       pin_dir_o
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {
    SSW_RUN,
    SSW_STALL,
    SSW_DELAY
  } ssw_state_t;

  ssw_state_t                  state_q;
  ssw_state_t                  state_d;
  logic [ssw_pkg::PC_W-1:0]    pc_q;
  logic [ssw_pkg::PC_W-1:0]    pc_d;
  logic [ssw_pkg::FIELD_W-1:0] dly_q;
  logic [ssw_pkg::FIELD_W-1:0] dly_d;
  logic [ssw_pkg::GPIO_N-1:0]  lvl_q;
  logic [ssw_pkg::GPIO_N-1:0]  lvl_d;
  logic [ssw_pkg::GPIO_N-1:0]  dir_q;
  logic [ssw_pkg::GPIO_N-1:0]  dir_d;

  // ==========================================================================
  // Side-set decode
  logic                        side_apply;
  logic [ssw_pkg::GPIO_N-1:0]  side_mask;
  logic [ssw_pkg::GPIO_N-1:0]  side_value;
  logic [ssw_pkg::FIELD_W-1:0] side_delay;

  ssw_side_decode u_decode (
    .field_i      (exec_i.word[ssw_pkg::FIELD_MSB:ssw_pkg::FIELD_LSB]),
    .count_i      (cfg_i.side_bit_count),
    .enable_opt_i (cfg_i.side_enable_opt),
    .first_gpio_i (cfg_i.side_first_gpio),
    .apply_o      (side_apply),
    .mask_o       (side_mask),
    .value_o      (side_value),
    .delay_o      (side_delay)
  );

  // ==========================================================================
  // Instruction qualification
  logic                        in_run;
  logic                        in_stall;
  logic                        first_cyc;
  logic                        side_fire;
  logic                        side_lvl;
  logic                        side_dir;
  logic                        retire_now;
  logic                        has_delay;

  // Taken only in RUN; waits in STALL, ignored in DELAY
  assign in_run     = (state_q == SSW_RUN);
  assign in_stall   = (state_q == SSW_STALL);
  assign first_cyc  = in_run & exec_i.valid;

  // Side-set fires only on the first cycle, so a stall does not repeat it
  assign side_fire  = first_cyc & side_apply;
  assign side_lvl   = side_fire & ~cfg_i.side_targets_direction;
  assign side_dir   = side_fire & cfg_i.side_targets_direction;

  // Retire on the first cycle, or on the cycle a stall lifts
  assign retire_now = exec_i.valid & ~exec_i.stall & (in_run | in_stall);
  assign has_delay  = (side_delay != ssw_pkg::DELAY_ZERO);

  // ==========================================================================
  // Pin merge: OUT/SET first, then side-set on top
  logic [ssw_pkg::GPIO_N-1:0]  lvl_core;
  logic [ssw_pkg::GPIO_N-1:0]  dir_core;
  logic [ssw_pkg::GPIO_N-1:0]  lvl_smask;
  logic [ssw_pkg::GPIO_N-1:0]  dir_smask;

  // OUT/SET writes land whenever their mask is set, delay cycles included
  assign lvl_core  = (lvl_q & ~out_wr_i.mask) | (out_wr_i.value & out_wr_i.mask);
  assign dir_core  = (dir_q & ~dir_wr_i.mask) | (dir_wr_i.value & dir_wr_i.mask);

  // Only one side-set mask is ever open, chosen by the direction option
  assign lvl_smask = side_lvl ? side_mask : ssw_pkg::GPIO_RST;
  assign dir_smask = side_dir ? side_mask : ssw_pkg::GPIO_RST;

  // Side-set laid last so it wins on pins that OUT/SET also wrote
  assign lvl_d = (lvl_core & ~lvl_smask) | (side_value & lvl_smask);
  assign dir_d = (dir_core & ~dir_smask) | (side_value & dir_smask);

  // ==========================================================================
  // Next PC: jump, then wrap, then increment; all in the retiring cycle
  logic                        at_wrap_top;
  logic [ssw_pkg::PC_W-1:0]    pc_inc;
  logic [ssw_pkg::PC_W-1:0]    pc_wrap;
  logic [ssw_pkg::PC_W-1:0]    pc_next;

  // Absolute compare: a program at an offset needs offset wrap values
  assign at_wrap_top = (pc_q == cfg_i.loop_end_address);

  // Plain roll from the last slot back to slot zero
  assign pc_inc  = (pc_q == ssw_pkg::PC_LAST) ? ssw_pkg::PC_RST
                                              : pc_q + ssw_pkg::PC_ONE;

  // Wrap folded into the retiring instruction, so it costs no cycle
  assign pc_wrap = at_wrap_top ? cfg_i.loop_start_address : pc_inc;

  // A taken jump outranks the wrap
  assign pc_next = exec_i.jump_taken ? exec_i.jump_target : pc_wrap;

  // PC holds through stall and delay cycles
  assign pc_d    = retire_now ? pc_next : pc_q;

  // ==========================================================================
  // Delay capture. The word may change while stalled, so the delay is
  // latched in the first cycle and counting starts only after the stall.
  logic [ssw_pkg::FIELD_W-1:0] dly_hold_q;
  logic [ssw_pkg::FIELD_W-1:0] dly_hold_d;
  logic [ssw_pkg::FIELD_W-1:0] dly_use;

  assign dly_hold_d = first_cyc ? side_delay : dly_hold_q;
  assign dly_use    = in_run ? side_delay : dly_hold_q;

  // ==========================================================================
  // Sequencer: next state and delay countdown

  always_comb
  begin
    state_d = state_q;
    dly_d   = dly_q;
    case (state_q)
      // Take a new instruction; stall or delay decide where to go
      SSW_RUN:
      begin
        if (exec_i.valid && exec_i.stall)
        begin
          state_d = SSW_STALL;
        end
        else if (exec_i.valid && has_delay)
        begin
          state_d = SSW_DELAY;
          dly_d   = side_delay;
        end
      end
      // Wait for the stall to lift, then start the latched delay
      SSW_STALL:
      begin
        if (retire_now)
        begin
          if (dly_use != ssw_pkg::DELAY_ZERO)
          begin
            state_d = SSW_DELAY;
            dly_d   = dly_use;
          end
          else
          begin
            state_d = SSW_RUN;
          end
        end
      end
      // Idle cycles; inputs from the core are ignored here
      SSW_DELAY:
      begin
        // Exactly dly cycles idle, then back to fetch
        if (dly_q == ssw_pkg::DELAY_ONE)
        begin
          state_d = SSW_RUN;
          dly_d   = ssw_pkg::DELAY_ZERO;
        end
        else
        begin
          dly_d = dly_q - ssw_pkg::DELAY_ONE;
        end
      end
      // Unused encoding falls back to fetch
      default:
      begin
        state_d = SSW_RUN;
        dly_d   = ssw_pkg::DELAY_ZERO;
      end
    endcase
  end

  // ==========================================================================
  // Registers: one short block per register so each reset value sits
  // beside its own next-value assignment

  // Sequencer state
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= SSW_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Program counter
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_q <= ssw_pkg::PC_RST;
    end
    else
    begin
      pc_q <= pc_d;
    end
  end

  // Delay countdown
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dly_q <= ssw_pkg::DELAY_ZERO;
    end
    else
    begin
      dly_q <= dly_d;
    end
  end

  // Delay latched at the first cycle of a stalled instruction
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dly_hold_q <= ssw_pkg::DELAY_ZERO;
    end
    else
    begin
      dly_hold_q <= dly_hold_d;
    end
  end

  // Pin levels
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lvl_q <= ssw_pkg::GPIO_RST;
    end
    else
    begin
      lvl_q <= lvl_d;
    end
  end

  // Pin directions; every pin an input after reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dir_q <= ssw_pkg::GPIO_RST;
    end
    else
    begin
      dir_q <= dir_d;
    end
  end

  // ==========================================================================
  // Outputs
  // Data outputs straight from flip-flops
  assign pc_o          = pc_q;
  assign pin_level_o   = lvl_q;
  assign pin_dir_o     = dir_q;
  assign busy_o        = (state_q != SSW_RUN);
  // Core may present a new instruction only in RUN, or keep the stalled one
  assign fetch_ready_o = (state_q != SSW_DELAY);

endmodule // ssw_core

/* test/ssw_pad_model.sv */
/*
  Pad model for the GPIO pins that ssw_core drives.
  Assumes a pin drives its pad only while its output enable is high.
*/
`timescale 1ns/1ps
module ssw_pad_model (
  input  wire logic [ssw_pkg::GPIO_N-1:0] pin_level_i,
  input  wire logic [ssw_pkg::GPIO_N-1:0] pin_dir_i,
  input  wire logic                       clk_i,
  output logic      [ssw_pkg::GPIO_N-1:0] pad_o
);
  // ==========================================================================
  // Undriven pads flip every cycle: no pull is known, so stale levels never pass
  logic [ssw_pkg::GPIO_N-1:0] float_q = '0;
  always_ff @(posedge clk_i) float_q <= ~float_q;
  assign pad_o = (pin_dir_i & pin_level_i) | (~pin_dir_i & float_q);
endmodule // ssw_pad_model

/* test/ssw_core_checker.sv */
/*
  Checker bound to ssw_core: pc stepping, delay idle and side-set pins.
  Assumes configuration is held steady while instructions run.
*/
`timescale 1ns/1ps
module ssw_core_checker (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire ssw_pkg::ssw_cfg_t          cfg_i,
  input wire ssw_pkg::ssw_exec_t         exec_i,
  input wire ssw_pkg::ssw_pinwr_t        out_wr_i,
  input wire ssw_pkg::ssw_pinwr_t        dir_wr_i,
  input wire logic [ssw_pkg::PC_W-1:0]   pc_o,
  input wire logic                       busy_o,
  input wire logic                       fetch_ready_o,
  input wire logic [ssw_pkg::GPIO_N-1:0] pin_level_o,
  input wire logic [ssw_pkg::GPIO_N-1:0] pin_dir_o
);
  // ==========================================================================
  // Field decode; counts above five clamp as in the design
  logic [2:0] cnt;
  logic [4:0] fld, dly, sh, b;
  logic       take, done, on, jmp, stp, top, sl, sd, quiet;
  assign cnt   = (cfg_i.side_bit_count > 3'h5) ? 3'h5 : cfg_i.side_bit_count;
  assign fld   = exec_i.word[12:8];
  assign dly   = fld & (5'h1f >> cnt);
  assign sh    = fld >> (3'h5 - cnt);
  assign b     = cfg_i.side_first_gpio;
  assign take  = exec_i.valid && fetch_ready_o && !busy_o;
  assign done  = exec_i.valid && !exec_i.stall && fetch_ready_o;
  assign on    = (cnt != 3'h0) && (!cfg_i.side_enable_opt || (fld[4] && cnt > 3'h1));
  assign jmp   = done && exec_i.jump_taken;
  assign stp   = done && !exec_i.jump_taken;
  assign top   = pc_o == cfg_i.loop_end_address;
  assign sl    = take && on && !cfg_i.side_targets_direction;
  assign sd    = take && on && cfg_i.side_targets_direction;
  assign quiet = take && !on && out_wr_i.mask == '0 && dir_wr_i.mask == '0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Program counter and idle cycles
  a_pc_jump: assert property (jmp |=> pc_o == $past(exec_i.jump_target))
    else $error("pc missed the jump target");
  a_pc_wrap: assert property (stp && top |=> pc_o == cfg_i.loop_start_address)
    else $error("pc did not wrap");
  a_pc_step: assert property (stp && !top |=> pc_o == $past(pc_o) + 5'h01)
    else $error("pc did not step by one");
  a_no_idle: assert property (done && dly == 5'h00 |=> fetch_ready_o && !busy_o)
    else $error("idle after an undelayed instruction");
  a_idle_two: assert property (
    done && dly == 5'h02 |=> !fetch_ready_o [*2] ##1 fetch_ready_o)
    else $error("two delay cycles not kept");

  // ==========================================================================
  // Side-set pins
  a_side_lvl: assert property (sl |=> pin_level_o[$past(b)] == $past(sh[0]))
    else $error("side-set level not applied");
  a_side_dir: assert property (sd |=> pin_dir_o[$past(b)] == $past(sh[0]))
    else $error("side-set direction not applied");
  a_side_off: assert property (quiet |=> $stable({pin_level_o, pin_dir_o}))
    else $error("pins moved without side-set");
  c_wrap: cover property (stp && top);
  c_stall: cover property (take && exec_i.stall);
  c_delay: cover property (done && dly != 5'h00);
endmodule // ssw_core_checker

bind ssw_core ssw_core_checker u_ssw_core_checker (.clk_i, .rst_i, .cfg_i, .exec_i, .out_wr_i,
  .dir_wr_i, .pc_o, .busy_o, .fetch_ready_o, .pin_level_o, .pin_dir_o);

/* test/tb_ssw_core.sv */
/*
  Testbench for ssw_core: side-set, delay, stall and pc stepping.
  Assumes the checker binds itself; a pad model watches the pins.
*/
`timescale 1ns/1ps
module tb_ssw_core;
  // ==========================================================================
  // Signals and pc table (target 0 means no jump)
  logic                clk, rst;
  ssw_pkg::ssw_cfg_t   cfg;
  ssw_pkg::ssw_exec_t  ex;
  ssw_pkg::ssw_pinwr_t ow, dw;
  logic [4:0]          pc;
  logic                busy, frdy;
  logic [31:0]         lvl, dir, pad;
  int                  err_count, checked, idle;
  logic [4:0]          tg [7] = '{5'h05, 5'h00, 5'h00, 5'h06, 5'h09, 5'h1f, 5'h00};
  logic [4:0]          xp [7] = '{5'h05, 5'h06, 5'h02, 5'h06, 5'h09, 5'h1f, 5'h00};

  ssw_core u_ssw_core (.clk_i(clk), .rst_i(rst), .cfg_i(cfg), .exec_i(ex), .out_wr_i(ow),
    .dir_wr_i(dw), .pc_o(pc), .busy_o(busy), .fetch_ready_o(frdy), .pin_level_o(lvl),
    .pin_dir_o(dir));
  ssw_pad_model u_ssw_pad_model (.pin_level_i(lvl), .pin_dir_i(dir), .clk_i(clk), .pad_o(pad));

  // 40 ns clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Loop start 2, loop end 6 kept throughout
  task automatic setc(input logic [2:0] c, input logic e, input logic [4:0] b, input logic d);
    @(posedge clk);
    cfg <= {c, e, b, d, 5'h06, 5'h02};
  endtask

  task automatic put(input logic [4:0] f, input logic j, input logic [4:0] t, input logic s);
    @(posedge clk);
    ex <= {1'b1, 3'h0, f, 8'h00, s, j, t};
  endtask

  // One instruction, then count idle cycles under a bound
  task automatic issue(input logic [4:0] f, input logic [4:0] t);
    put(f, t != 5'h00, t, 1'b0);
    @(posedge clk);
    ex.valid <= 1'b0;
    idle = 0;
    #1;
    while (frdy !== 1'b1 && idle < 40)
    begin
      @(posedge clk);
      #1;
      idle++;
    end
    if (idle == 40)
    begin
      err_count++;
      give_verdict();
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    ex = '0;
    ow = '0;
    dw = '0;
    cfg = {3'h2, 1'b0, 5'h04, 1'b0, 5'h06, 5'h02};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({busy, frdy, pc}, 7'h20);
    check(lvl | dir, 32'h0);
    issue(5'h12, 5'h00);
    check(lvl[5:4], 2'h2);
    check(idle, 2);
    $display("test walk done");
    for (int i = 0; i < 7; i++)
    begin
      issue(5'h00, tg[i]);
      check(pc, xp[i]);
      check(idle, 0);
    end
    $display("test pc done");
    setc(3'h3, 1'b1, 5'h1e, 1'b0);
    issue(5'h1c, 5'h00);
    check(lvl[31:30], 2'h3);
    issue(5'h08, 5'h00);
    check(lvl[31:30], 2'h3);
    setc(3'h0, 1'b0, 5'h04, 1'b0);
    issue(5'h1f, 5'h00);
    check(idle, 31);
    check(lvl, 32'hc0000000);
    setc(3'h5, 1'b0, 5'h00, 1'b1);
    issue(5'h15, 5'h00);
    check(dir, 32'h15);
    check(pad & dir, 32'h0);
    $display("test modes done");
    setc(3'h1, 1'b0, 5'h02, 1'b0);
    put(5'h10, 1'b0, 5'h00, 1'b0);
    ow <= {32'hffffffff, 32'h0};
    dw <= {32'h00000001, 32'h0};
    @(posedge clk);
    ex.valid <= 1'b0;
    ow <= '0;
    dw <= '0;
    #1;
    check(lvl, 32'h4);
    check(dir, 32'h14);
    put(5'h00, 1'b0, 5'h00, 1'b1);
    @(posedge clk);
    #1;
    check({busy, lvl[2], pc}, 7'h45);
    @(posedge clk);
    ex.stall <= 1'b0;
    @(posedge clk);
    ex.valid <= 1'b0;
    #1;
    check(pc, 5'h06);
    $display("test overlap and stall done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check({busy, frdy, pc, lvl | dir}, 39'h2000000000);
    $display("test reset done");
    give_verdict();
  end
endmodule // tb_ssw_core
